// ---- src/gp5_params.svh ----
// constants for the five-bit port with oscillator takeover
`ifndef GP5_PARAMS_SVH
`define GP5_PARAMS_SVH
`define GP5_W 5
`define GP5_AW 20
`define GP5_IDX_LATCH 20'h07fd0
`define GP5_IDX_INPUT 20'h07fd1
`define GP5_IDX_DIR 20'h07fd2
`define GP5_IDX_OSC 20'h07fd8
`define GP5_RST_LATCH 5'h00
`define GP5_RST_DIR 5'h00
`define GP5_RST_OSC 8'h00
`define GP5_XT_A 2
`define GP5_XT_B 0
`define GP5_CF_A 7
`define GP5_CF_B 3
`define GP5_CF_C 1
`define GP5_XT_MASK 5'h03
`define GP5_CF_MASK 5'h18
`define GP5_PULL_MASK 5'h04
`define GP5_RESP_OKAY 2'h0
`define GP5_RESP_SLVERR 2'h2
`endif

// ---- src/gp5_pkg.sv ----
// types shared by the five-bit port
`include "gp5_params.svh"
package gp5_pkg;
   typedef enum logic [2:0] {
      GP5_SEL_LATCH,
      GP5_SEL_INPUT,
      GP5_SEL_DIR,
      GP5_SEL_OSC,
      GP5_SEL_NONE
   } gp5_sel_e;

   typedef struct packed {
      logic aw_full;
      logic [`GP5_AW-1:0] aw_addr;
      logic w_full;
      logic [7:0] w_data;
      logic w_lane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic awready;
      logic wready;
      logic arready;
      logic [`GP5_W-1:0] latch;
      logic [`GP5_W-1:0] dir;
      logic [7:0] osc;
      logic [`GP5_W-1:0] sync1;
      logic [`GP5_W-1:0] sync2;
      logic [`GP5_W-1:0] pin_out;
      logic [`GP5_W-1:0] pin_oe_n;
      logic [`GP5_W-1:0] pull_en;
      logic xt_run;
      logic cf_run;
   } gp5_state_s;
endpackage : gp5_pkg

// ---- src/gp5_port.sv ----
// five-bit port with crystal and ceramic oscillator takeover, axi4-lite registers
//
// Overview of operation
// - five-bit output latch, resets to zero
// - per-bit direction, 1 output, reset input
// - input view always shows pin levels after a two-flop synchroniser
// - selected oscillator overrides latch and direction
// - bits 0,1 crystal when control bits 2,0
// - gp bits drive when output, else float
// - bits 3,4 ceramic when control bits 7,3,1
// - bit 2 pull-up when input and latch 1
// - halt freezes every port bit at entry
// - deep hold keeps outputs, oscillator pins revert
`timescale 1ns/1ps
`include "gp5_params.svh"
module gp5_port
   import gp5_pkg::*;
#(
   parameter int ADDR_W = `GP5_AW
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic ce,
   input wire logic halt_req,
   input wire logic deep_hold_req,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [`GP5_W-1:0] pin_in,
   output logic [`GP5_W-1:0] pin_out,
   output logic [`GP5_W-1:0] pin_oe_n,
   output logic [`GP5_W-1:0] pin_pullup_en,
   output logic crystal_run,
   output logic ceramic_run
);

   gp5_state_s s_reg;
   gp5_state_s s_next;

   // byte address is four times the register index
   function automatic gp5_sel_e decode(input logic [ADDR_W-1:0] addr);
      logic [ADDR_W+1:0] idx4;
      idx4 = {2'h0, addr};
      if (idx4 == ({2'h0, ADDR_W'(`GP5_IDX_LATCH)} << 2)) return GP5_SEL_LATCH;
      if (idx4 == ({2'h0, ADDR_W'(`GP5_IDX_INPUT)} << 2)) return GP5_SEL_INPUT;
      if (idx4 == ({2'h0, ADDR_W'(`GP5_IDX_DIR)} << 2)) return GP5_SEL_DIR;
      if (idx4 == ({2'h0, ADDR_W'(`GP5_IDX_OSC)} << 2)) return GP5_SEL_OSC;
      return GP5_SEL_NONE;
   endfunction : decode

   logic xt_sel;
   logic cf_sel;
   logic [`GP5_W-1:0] osc_mask;
   logic [`GP5_W-1:0] gp_oe_n;
   logic [`GP5_W-1:0] gp_pull;
   logic [`GP5_W-1:0] keep;
   logic do_write;
   gp5_sel_e wsel;
   gp5_sel_e rsel;

   assign xt_sel = s_reg.osc[`GP5_XT_A] & s_reg.osc[`GP5_XT_B];
   assign cf_sel = s_reg.osc[`GP5_CF_A] & s_reg.osc[`GP5_CF_B] & s_reg.osc[`GP5_CF_C];
   // oscillator takeover is dropped in deep hold so those pins fall back to the port
   assign osc_mask = deep_hold_req ? '0 :
                     ((xt_sel ? `GP5_XT_MASK : '0) | (cf_sel ? `GP5_CF_MASK : '0));
   assign gp_oe_n = ~s_reg.dir;
   assign gp_pull = ~s_reg.dir & s_reg.latch & `GP5_PULL_MASK;
   // halt holds all; deep hold holds all but the pins an oscillator had
   assign keep = halt_req ? '1 :
                 deep_hold_req ? ~((s_reg.xt_run ? `GP5_XT_MASK : '0) |
                                   (s_reg.cf_run ? `GP5_CF_MASK : '0)) : '0;
   assign do_write = s_reg.aw_full & s_reg.w_full & ~s_reg.bvalid;
   assign wsel = decode(s_reg.aw_addr);
   assign rsel = decode(s_axi_araddr);

   always_comb begin
      s_next = s_reg;
      // synchroniser, first stage only feeds the second
      s_next.sync1 = pin_in;
      s_next.sync2 = s_reg.sync1;
      if (s_axi_awvalid && s_reg.awready) begin
         s_next.aw_full = 1'b1;
         s_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_reg.wready) begin
         s_next.w_full = 1'b1;
         s_next.w_data = s_axi_wdata[7:0];
         s_next.w_lane = s_axi_wstrb[0];
      end
      if (s_reg.bvalid && s_axi_bready) begin
         s_next.bvalid = 1'b0;
      end
      if (do_write) begin
         s_next.aw_full = 1'b0;
         s_next.w_full = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = `GP5_RESP_OKAY;
         case (wsel)
            GP5_SEL_LATCH: begin
               if (s_reg.w_lane) s_next.latch = s_reg.w_data[`GP5_W-1:0];
            end
            GP5_SEL_DIR: begin
               if (s_reg.w_lane) s_next.dir = s_reg.w_data[`GP5_W-1:0];
            end
            GP5_SEL_OSC: begin
               if (s_reg.w_lane) s_next.osc = s_reg.w_data;
            end
            GP5_SEL_INPUT: begin
               s_next.bresp = `GP5_RESP_OKAY;
            end
            default: begin
               s_next.bresp = `GP5_RESP_SLVERR;
            end
         endcase
      end
      if (s_reg.rvalid && s_axi_rready) begin
         s_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && s_reg.arready) begin
         s_next.rvalid = 1'b1;
         s_next.rresp = `GP5_RESP_OKAY;
         case (rsel)
            GP5_SEL_LATCH: s_next.rdata = {27'h0, s_reg.latch};
            GP5_SEL_INPUT: s_next.rdata = {27'h0, s_reg.sync2};
            GP5_SEL_DIR: s_next.rdata = {27'h0, s_reg.dir};
            GP5_SEL_OSC: s_next.rdata = {24'h0, s_reg.osc};
            default: begin
               s_next.rdata = 32'h0;
               s_next.rresp = `GP5_RESP_SLVERR;
            end
         endcase
      end
      s_next.awready = ~s_next.aw_full & ~s_next.bvalid;
      s_next.wready = ~s_next.w_full & ~s_next.bvalid;
      s_next.arready = ~s_next.rvalid;
      // pin drive; an oscillator pin is released from the port driver
      for (int i = 0; i < `GP5_W; i++) begin
         if (!keep[i]) begin
            if (osc_mask[i]) begin
               s_next.pin_out[i] = 1'b0;
               s_next.pin_oe_n[i] = 1'b1;
               s_next.pull_en[i] = 1'b0;
            end else begin
               s_next.pin_out[i] = s_reg.latch[i];
               s_next.pin_oe_n[i] = gp_oe_n[i];
               s_next.pull_en[i] = gp_pull[i];
            end
         end
      end
      if (!halt_req) begin
         s_next.xt_run = |(osc_mask & `GP5_XT_MASK);
         s_next.cf_run = |(osc_mask & `GP5_CF_MASK);
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         s_reg <= '0;
         s_reg.latch <= `GP5_RST_LATCH;
         s_reg.dir <= `GP5_RST_DIR;
         s_reg.osc <= `GP5_RST_OSC;
         s_reg.pin_oe_n <= '1;
      end else if (ce) begin
         s_reg <= s_next;
      end
   end

   assign s_axi_awready = s_reg.awready;
   assign s_axi_wready = s_reg.wready;
   assign s_axi_bvalid = s_reg.bvalid;
   assign s_axi_bresp = s_reg.bresp;
   assign s_axi_arready = s_reg.arready;
   assign s_axi_rvalid = s_reg.rvalid;
   assign s_axi_rdata = s_reg.rdata;
   assign s_axi_rresp = s_reg.rresp;
   assign pin_out = s_reg.pin_out;
   assign pin_oe_n = s_reg.pin_oe_n;
   assign pin_pullup_en = s_reg.pull_en;
   assign crystal_run = s_reg.xt_run;
   assign ceramic_run = s_reg.cf_run;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   logic run;
   assign run = ce & ~halt_req & ~deep_hold_req;

   sequence s_latch_commit;
      ce && do_write && wsel == GP5_SEL_LATCH && s_reg.w_lane;
   endsequence

   sequence s_input_read;
      ce && s_axi_arvalid && s_reg.arready && rsel == GP5_SEL_INPUT;
   endsequence

   sequence s_latch_read;
      ce && s_axi_arvalid && s_reg.arready && rsel == GP5_SEL_LATCH;
   endsequence

   sequence s_dir_commit;
      ce && do_write && wsel == GP5_SEL_DIR && s_reg.w_lane;
   endsequence

   sequence s_dir_read;
      ce && s_axi_arvalid && s_reg.arready && rsel == GP5_SEL_DIR;
   endsequence

   a_latch_write: assert property (
      s_latch_commit |=> s_reg.latch == $past(s_reg.w_data[4:0]) && s_axi_bvalid)
      else $error("latch write not stored");

   a_dir_drive: assert property (
      run && s_reg.dir[2] ##1 run [*1] |-> !pin_oe_n[2] && pin_out[2] == $past(s_reg.latch[2]))
      else $error("output bit not driven from latch");

   a_input_view: assert property (
      s_input_read |=> s_axi_rvalid && s_axi_rdata == {27'h0, $past(s_reg.sync2)})
      else $error("input view wrong");

   a_xt_override: assert property (
      run && xt_sel |=> pin_oe_n[1:0] == 2'b11 && crystal_run)
      else $error("crystal pins not taken over");

   a_cf_override: assert property (
      run && cf_sel |=> pin_oe_n[4:3] == 2'b11 && ceramic_run)
      else $error("ceramic pins not taken over");

   a_float_input: assert property (
      run && !xt_sel && !s_reg.dir[0] |=> pin_oe_n[0] && !pin_pullup_en[0])
      else $error("input bit not floating");

   a_pullup_bit2: assert property (
      run && !s_reg.dir[2] && s_reg.latch[2] |=> pin_oe_n[2] && pin_pullup_en[2])
      else $error("bit two pull-up missing");

   a_upper_zero: assert property (
      s_latch_read |=> s_axi_rdata[31:5] == 27'h0)
      else $error("upper latch bits not zero");

   a_halt_freeze: assert property (
      ce && halt_req |=> $stable(pin_out) && $stable(pin_oe_n) && $stable(pin_pullup_en))
      else $error("port moved during halt");

   a_deep_revert: assert property (
      ce && deep_hold_req && !halt_req && crystal_run |=> !crystal_run && $stable(pin_oe_n[2]))
      else $error("deep hold handling wrong");

   a_latch_reset: assert property (
      $rose(rstn) |-> s_reg.latch == `GP5_RST_LATCH && pin_oe_n == '1)
      else $error("latch not cleared by reset");

   a_dir_reset: assert property (
      $rose(rstn) |-> s_reg.dir == `GP5_RST_DIR && !crystal_run && !ceramic_run)
      else $error("direction not cleared by reset");

   a_dir_write: assert property (
      s_dir_commit |=> s_reg.dir == $past(s_reg.w_data[4:0]) && s_axi_bvalid)
      else $error("direction write not stored");

   a_dir_upper: assert property (
      s_dir_read |=> s_axi_rdata == {27'h0, $past(s_reg.dir)})
      else $error("direction read wrong");

   a_xt_priority: assert property (
      run && xt_sel && s_reg.dir[0] |=> pin_oe_n[0] && !pin_out[0])
      else $error("crystal pin driven by port");

   a_cf_priority: assert property (
      run && cf_sel && s_reg.dir[3] |=> pin_oe_n[3] && !pin_out[3])
      else $error("ceramic pin driven by port");

   a_gp_drive: assert property (
      run && !cf_sel && s_reg.dir[4] |=> !pin_oe_n[4] && pin_out[4] == $past(s_reg.latch[4]))
      else $error("port bit four not driven");

   a_no_pullup: assert property (
      run |=> pin_pullup_en[1:0] == 2'b00 && pin_pullup_en[4:3] == 2'b00)
      else $error("pull-up on a bit without one");

   a_bit2_open: assert property (
      run && !s_reg.dir[2] && !s_reg.latch[2] |=> pin_oe_n[2] && !pin_pullup_en[2])
      else $error("bit two not open");

   a_halt_flags: assert property (
      ce && halt_req |=> $stable(crystal_run) && $stable(ceramic_run))
      else $error("oscillator flags moved during halt");

   a_deep_hold: assert property (
      ce && deep_hold_req && !halt_req && !crystal_run && !ceramic_run |=>
         $stable(pin_out) && $stable(pin_oe_n) && $stable(pin_pullup_en))
      else $error("port moved during deep hold");

   a_cf_revert: assert property (
      ce && deep_hold_req && !halt_req && ceramic_run |=>
         !ceramic_run && pin_oe_n[4:3] == ~$past(s_reg.dir[4:3]))
      else $error("ceramic pins not returned to port");

endmodule : gp5_port

// ---- tb/gp5_pins.sv ----
// pin model: design drive, outside drive, pull-up, floating noise
`timescale 1ns/1ps
module gp5_pins (
   input wire logic clk,
   input wire logic [4:0] po,
   input wire logic [4:0] oe_n,
   input wire logic [4:0] pu,
   input wire logic [4:0] en,
   input wire logic [4:0] ev,
   output logic [4:0] pi
);
   logic [4:0] noise = 5'h15;
   // an open line has no keeper, so it never shows a stale level
   always @(posedge clk) noise <= ~noise;
   assign pi = (~oe_n & po) | (oe_n & en & ev) | (oe_n & ~en & (pu | noise));
endmodule : gp5_pins

// ---- tb/tb_gp5_port.sv ----
// self-checking bench for the five-bit port
`timescale 1ns/1ps
module tb_gp5_port;
   logic clk = 0, rstn = 0, ce = 1, halt = 0, deep = 0, awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
   logic [19:0] awa = '0, ara = '0;
   logic [31:0] wd = '0, v;
   logic [1:0] r;
   logic [4:0] en = '0, ev = '0;
   logic [16:0] he;
   wire logic awr, wr_, bv, arr, rv, xt, cf;
   wire logic [1:0] bresp, rresp;
   wire logic [31:0] rdata;
   wire logic [4:0] po, oe_n, pu, pi;
   int fail_count = 0, compares = 0, lat, dir, seed = 32'h68064707;
   int oscs[$] = {'h05, 'h8a, 'h04, 'h0a, 'h8f};
   always #10 clk = ~clk;
   gp5_port uut (.clk(clk), .rstn(rstn), .ce(ce), .halt_req(halt), .deep_hold_req(deep),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
      .s_axi_wvalid(wv), .s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
      .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .pin_in(pi), .pin_out(po),
      .pin_oe_n(oe_n), .pin_pullup_en(pu), .crystal_run(xt), .ceramic_run(cf));
   gp5_pins pins (.clk(clk), .po(po), .oe_n(oe_n), .pu(pu), .en(en), .ev(ev), .pi(pi));
   task end_of_test;
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : end_of_test
   task chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e) begin
         $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
         fail_count++;
      end
   endtask : chk
   task tmo(input logic done);
      if (!done) begin
         fail_count++;
         end_of_test();
      end
   endtask : tmo
   task wr(input logic [19:0] a, input logic [31:0] d, output logic [1:0] rs);
      int n;
      logic tb;
      n = 0;
      @(posedge clk);
      awa <= a;
      wd <= d;
      awv <= 1;
      wv <= 1;
      br <= 1;
      do begin
         @(posedge clk);
         tb = bv;
         rs = bresp;
         if (awv && awr) awv <= 0;
         if (wv && wr_) wv <= 0;
         n++;
      end while (!tb && n < 50);
      br <= 0;
      tmo(tb);
   endtask : wr
   task rd(input logic [19:0] a, output logic [31:0] d, output logic [1:0] rs);
      int n;
      logic tr;
      n = 0;
      @(posedge clk);
      ara <= a;
      arv <= 1;
      rr <= 1;
      do begin
         @(posedge clk);
         tr = rv;
         d = rdata;
         rs = rresp;
         if (arv && arr) arv <= 0;
         n++;
      end while (!tr && n < 50);
      rr <= 0;
      tmo(tr);
   endtask : rd
   // oscillator pins must read as released, so their drive value is masked
   function automatic logic [16:0] pexp(input int l, input int d, input int o);
      logic [4:0] oe;
      logic x, c;
      x = o[2] & o[0];
      c = o[7] & o[3] & o[1];
      oe = ~d[4:0] | {c, c, 1'h0, x, x};
      return {c, x, 2'h0, ~d[2] & l[2], 2'h0, oe, l[4:0] & ~oe};
   endfunction : pexp
   task cp(input logic [16:0] e);
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk({cf, xt, pu, oe_n, po & ~oe_n}, e);
   endtask : cp
   initial begin
      repeat (12) @(posedge clk);
      rstn <= 1;
      rd(20'h1ff40, v, r);
      chk(v, 32'h0);
      rd(20'h1ff48, v, r);
      chk(v, 32'h0);
      cp(pexp(0, 0, 0));
      for (int i = 0; i < 8; i++) begin
         lat = $random(seed) & 'hff;
         dir = $random(seed) & 'hff;
         wr(20'h1ff40, lat, r);
         chk(r, 2'h0);
         wr(20'h1ff48, dir, r);
         chk(r, 2'h0);
         v = $random(seed);
         ev <= v[4:0];
         en <= ~dir[4:0];
         lat &= 'h1f;
         dir &= 'h1f;
         cp(pexp(lat, dir, 0));
         rd(20'h1ff40, v, r);
         chk(v, lat);
         rd(20'h1ff48, v, r);
         chk(v, dir);
         rd(20'h1ff44, v, r);
         chk(v, (lat & dir) | (ev & ~dir[4:0]));
      end
      rd(20'h1ff4c, v, r);
      chk(r, 2'h2);
      chk(v, 32'h0);
      wr(20'h1ff4c, 'h1f, r);
      chk(r, 2'h2);
      wr(20'h1ff44, 'h1f, r);
      chk(r, 2'h0);
      rd(20'h1ff40, v, r);
      chk(v, lat);
      foreach (oscs[k]) begin
         wr(20'h1ff60, oscs[k], r);
         cp(pexp(lat, dir, oscs[k]));
      end
      // clock enable low must hold off the deep hold change
      @(posedge clk);
      ce <= 0;
      deep <= 1;
      cp(pexp(lat, dir, 'h8f));
      @(posedge clk);
      ce <= 1;
      he = pexp(lat, dir, 0);
      cp(he);
      wr(20'h1ff40, ~lat, r);
      lat = ~lat & 'h1f;
      cp(he);
      @(posedge clk);
      deep <= 0;
      he = pexp(lat, dir, 'h8f);
      cp(he);
      @(posedge clk);
      halt <= 1;
      wr(20'h1ff48, ~dir, r);
      dir = ~dir & 'h1f;
      cp(he);
      @(posedge clk);
      halt <= 0;
      cp(pexp(lat, dir, 'h8f));
      @(posedge clk);
      rstn <= 0;
      repeat (2) @(posedge clk);
      rstn <= 1;
      rd(20'h1ff40, v, r);
      chk(v, 32'h0);
      rd(20'h1ff48, v, r);
      chk(v, 32'h0);
      cp(pexp(0, 0, 0));
      end_of_test();
   end
endmodule : tb_gp5_port
